/* src/trim_prog_pkg.sv */
// package for the reference trim programmer: pin carriers, timing, trim coding
// assumes a 125 MHz core clock and comparator outputs for the pin levels
package trim_prog_pkg;

  // core clock
  localparam int CLK_PERIOD_NS = 8;

  // pin timing as printed
  localparam int START_MIN_NS = 10000;
  localparam int GAP_MIN_NS = 8000;
  localparam int BIT_PERIOD_NS = 1000;
  localparam int COMMIT_MIN_MS = 15;

  // counter widths
  localparam int PULSE_CNT_W = 11;
  localparam int COMMIT_CNT_W_DEF = 21;

  // derived cycle counts; least times round up
  localparam int START_CYC_I = (START_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_CYC_I = (GAP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int THRESH_CYC_I = (BIT_PERIOD_NS / 2) / CLK_PERIOD_NS;
  localparam int COMMIT_CYC_DEF = (COMMIT_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [PULSE_CNT_W-1:0] START_CYC = PULSE_CNT_W'(START_CYC_I);
  localparam logic [PULSE_CNT_W-1:0] GAP_CYC = PULSE_CNT_W'(GAP_CYC_I);
  localparam logic [PULSE_CNT_W-1:0] THRESH_CYC = PULSE_CNT_W'(THRESH_CYC_I);
  localparam logic [PULSE_CNT_W-1:0] PULSE_CNT_MAX = {PULSE_CNT_W{1'b1}};

  // trim word and programming group layout
  localparam int TRIM_W = 4;
  localparam int ADDR_W = 6;
  localparam int SEL_W = 2;
  localparam logic [TRIM_W-1:0] TRIM_DEFAULT = 4'hf;
  localparam logic [TRIM_W-1:0] TRIM_CODE_MAX = 4'hf;
  localparam int TRIM_SIGN_BIT = 3;
  localparam logic [ADDR_W-SEL_W-1:0] USER_ADDR_PREFIX = 4'h0;
  localparam logic [2:0] LAST_ADDR_IDX = 3'h6;
  localparam int OFFSET_W = 5;

  // comparator outputs of the two programming pins
  typedef struct packed {
    logic good_hv;    // good_flag_pin held at the 20 V programming level
    logic lock_high;  // lockout_program_pin at supply + 4 V
    logic lock_mid;   // lockout_program_pin at or above supply + 2 V
  } pin_levels_t;

  // command to the nonvolatile trim store
  typedef struct packed {
    logic write;
    logic [TRIM_W-1:0] code;
  } nvm_cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ARMED = 3'b001,
    ST_START = 3'b010,
    ST_GAP = 3'b011,
    ST_BITS = 3'b100
  } prog_state_t;

endpackage : trim_prog_pkg

/* src/level_sync.sv */
// two-flop synchroniser for a group of asynchronous levels
// assumes the levels change slowly against the clock
module level_sync
#(
  parameter int W = 1
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      meta_r <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule : level_sync

/* src/reference_trim_programmer.sv */
// reference trim programmer: decodes pulse-width-coded lockout pin sequences
// into a volatile trim buffer and commits it to the nonvolatile store.
// assumes analog comparators give pin levels and an external store keeps the code.
module reference_trim_programmer
  import trim_prog_pkg::*;
#(
  parameter int COMMIT_CYCLES = COMMIT_CYC_DEF,
  parameter int COMMIT_CNT_W = COMMIT_CNT_W_DEF
)
(
  input wire logic clk,
  input wire logic reset,
  input pin_levels_t pin_levels,
  input wire logic [TRIM_W-1:0] nvm_stored_code,
  output logic [TRIM_W-1:0] trim_code,
  output logic signed [OFFSET_W-1:0] ref_offset_mv,
  output nvm_cmd_t nvm_cmd,
  output logic prog_active
);

  pin_levels_t lv;
  logic [2:0] lv_vec;
  logic in_prog;
  logic mid_only;
  logic high_d_r;
  logic fall;
  prog_state_t state_r;
  prog_state_t state_nxt;
  logic [PULSE_CNT_W-1:0] cnt_r;
  logic [ADDR_W-1:0] addr_r;
  logic [2:0] bits_r;
  logic bit_strobe;
  logic bit_val;
  logic group_done;
  logic addr_valid;
  logic load_pend_r;
  logic [COMMIT_CNT_W-1:0] commit_cnt_r;
  logic commit_hold;

  level_sync #(.W(3)) u_pin_sync
  (
    .clk(clk),
    .reset(reset),
    .async_in(pin_levels),
    .sync_out(lv_vec)
  );

  assign lv = pin_levels_t'(lv_vec);

  // both pins at programming levels
  assign in_prog = lv.good_hv & (lv.lock_mid | lv.lock_high);
  assign mid_only = lv.lock_mid & ~lv.lock_high;
  assign fall = high_d_r & ~lv.lock_high;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      high_d_r <= 1'b0;
    else
      high_d_r <= lv.lock_high;
  end

  // sequence state
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
      begin
        if (in_prog && mid_only)
          state_nxt = ST_ARMED;
      end
      ST_ARMED:
      begin
        if (lv.lock_high)
          state_nxt = ST_START;
      end
      ST_START:
      begin
        if (!lv.lock_high)
          state_nxt = (cnt_r >= START_CYC) ? ST_GAP : ST_ARMED;
      end
      ST_GAP:
      begin
        if (lv.lock_high)
          state_nxt = (cnt_r >= GAP_CYC) ? ST_BITS : ST_START;
      end
      ST_BITS:
      begin
        // a hold as long as a start pulse restarts the sequence
        if (lv.lock_high && cnt_r >= START_CYC)
          state_nxt = ST_START;
      end
      default:
        state_nxt = ST_IDLE;
    endcase
    if (!in_prog)
      state_nxt = ST_IDLE;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // width and gap timer, cleared at each level change
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      cnt_r <= '0;
    else if (state_nxt != state_r || lv.lock_high != high_d_r)
      cnt_r <= '0;
    else if (cnt_r != PULSE_CNT_MAX)
      cnt_r <= cnt_r + 1'b1;
  end

  // a bit is decoded at the end of each high pulse in the bit phase
  assign bit_strobe = (state_r == ST_BITS) && fall && in_prog;
  assign bit_val = (cnt_r >= THRESH_CYC);
  assign group_done = bit_strobe && (bits_r == LAST_ADDR_IDX);

  // address shift register, first pulse ends up in the top bit
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      addr_r <= '0;
      bits_r <= '0;
    end
    else if (state_r != ST_BITS || state_nxt != ST_BITS)
    begin
      addr_r <= '0;
      bits_r <= '0;
    end
    else if (group_done)
    begin
      bits_r <= '0;
    end
    else if (bit_strobe)
    begin
      addr_r <= {addr_r[ADDR_W-2:0], bit_val};
      bits_r <= bits_r + 1'b1;
    end
  end

  assign addr_valid = (addr_r[ADDR_W-1:SEL_W] == USER_ADDR_PREFIX);

  // volatile trim buffer; reloads from the store after every reset
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      trim_code <= TRIM_DEFAULT;
      load_pend_r <= 1'b1;
    end
    else if (load_pend_r)
    begin
      trim_code <= nvm_stored_code;
      load_pend_r <= 1'b0;
    end
    else if (group_done && addr_valid)
    begin
      trim_code[addr_r[SEL_W-1:0]] <= bit_val;
    end
  end

  function automatic logic signed [OFFSET_W-1:0] trim_to_offset(input logic [TRIM_W-1:0] code);
    logic [TRIM_W-1:0] steps;
    logic signed [OFFSET_W-1:0] mag;
    steps = code[TRIM_SIGN_BIT] ? (TRIM_CODE_MAX - code) : {1'b0, code[TRIM_SIGN_BIT-1:0]};
    mag = signed'({1'b0, steps[TRIM_SIGN_BIT-1:0], 1'b0});
    return code[TRIM_SIGN_BIT] ? mag : -mag;
  endfunction : trim_to_offset

  // reference follows the buffer, not the store, one clock later
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      ref_offset_mv <= '0;
    else
      ref_offset_mv <= trim_to_offset(trim_code);
  end

  // commit hold timer; one write per continuous hold
  assign commit_hold = lv.good_hv & lv.lock_high;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      commit_cnt_r <= '0;
    else if (!commit_hold)
      commit_cnt_r <= '0;
    else if (commit_cnt_r != COMMIT_CNT_W'(COMMIT_CYCLES))
      commit_cnt_r <= commit_cnt_r + 1'b1;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      nvm_cmd <= '0;
    else
    begin
      nvm_cmd.write <= commit_hold && (commit_cnt_r == COMMIT_CNT_W'(COMMIT_CYCLES - 1));
      nvm_cmd.code <= trim_code;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      prog_active <= 1'b0;
    else
      prog_active <= (state_nxt != ST_IDLE);
  end

endmodule : reference_trim_programmer

/* verification/trim_prog_properties.sv */
// port assertions for the reference trim programmer
// assumes the bind at the foot attaches it to every design instance
module trim_prog_checker
  import trim_prog_pkg::*;
#(
  parameter int COMMIT_CYCLES = COMMIT_CYC_DEF,
  parameter int COMMIT_CNT_W = COMMIT_CNT_W_DEF
)
(
  input wire logic clk,
  input wire logic reset,
  input pin_levels_t pin_levels,
  input wire logic [TRIM_W-1:0] nvm_stored_code,
  input wire logic [TRIM_W-1:0] trim_code,
  input wire logic signed [OFFSET_W-1:0] ref_offset_mv,
  input nvm_cmd_t nvm_cmd,
  input wire logic prog_active
);
  timeunit 1ns;
  timeprecision 1ps;
  int hold_r;
  logic [1:0] up_r;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  function automatic logic signed [4:0] off_f(logic [3:0] c);
    return c[3] ? 5'(30 - 2 * int'(c)) : 5'(-2 * int'(c[2:0]));
  endfunction : off_f
  // pin cycles of unbroken commit level
  always_ff @(posedge clk or posedge reset)
    if (reset)
      hold_r <= 0;
    else
      hold_r <= (pin_levels.good_hv && pin_levels.lock_high) ? hold_r + 1 : 0;
  // top bit set once the store load has left the registers
  always_ff @(posedge clk or posedge reset)
    if (reset)
      up_r <= 2'h0;
    else
      up_r <= {up_r[0], 1'b1};
  sequence s_no_good;
    (!pin_levels.good_hv) [*6];
  endsequence
  sequence s_no_lock;
    (!pin_levels.lock_mid) [*6];
  endsequence
  a_offset_map: assert property (ref_offset_mv == off_f($past(trim_code)))
    else $error("offset does not follow trim code");
  a_cmd_copy: assert property (up_r[1] |-> nvm_cmd.code == $past(trim_code))
    else $error("store code is not the buffer");
  a_write_once: assert property (nvm_cmd.write |=> !nvm_cmd.write)
    else $error("store write longer than one cycle");
  a_write_hold: assert property (nvm_cmd.write |-> $past(hold_r, 4) >= COMMIT_CYCLES - 8)
    else $error("store write without long hold");
  a_trim_quiet: assert property (up_r[1] && $changed(trim_code) |-> $past(prog_active))
    else $error("trim changed while idle");
  a_one_bit: assert property (up_r[1] && $changed(trim_code) |-> $onehot(trim_code ^ $past(trim_code)))
    else $error("more than one trim bit changed");
  a_leave_good: assert property (s_no_good |-> !prog_active)
    else $error("active without good flag level");
  a_need_lock: assert property (s_no_lock |-> !prog_active)
    else $error("active without lockout level");
endmodule : trim_prog_checker

bind reference_trim_programmer trim_prog_checker #(.COMMIT_CYCLES(COMMIT_CYCLES), .COMMIT_CNT_W(COMMIT_CNT_W))
  trim_prog_checker_i (.clk(clk), .reset(reset), .pin_levels(pin_levels), .nvm_stored_code(nvm_stored_code),
  .trim_code(trim_code), .ref_offset_mv(ref_offset_mv), .nvm_cmd(nvm_cmd), .prog_active(prog_active));

/* verification/trim_fixture.sv */
// programming fixture model driving the pin comparator levels
// assumes its tasks are entered right after a rising clock edge
module trim_fixture
  import trim_prog_pkg::*;
(
  input wire logic clk,
  output pin_levels_t pins
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pins = '0;
  task automatic lv(input logic [2:0] v, input int n);
    pins <= v;
    repeat (n) @(posedge clk);
  endtask : lv
  task automatic enter();
    lv(3'b101, 10);
    lv(3'b111, 1260);
    lv(3'b101, 1010);
  endtask : enter
  task automatic pulse(input logic b);
    int w;
    w = b ? 70 + $urandom % 40 : 10 + $urandom % 40;
    lv(3'b111, w);
    lv(3'b101, 125 - w);
  endtask : pulse
  task automatic group(input logic [5:0] a, input logic d);
    for (int i = 5; i >= 0; i--)
      pulse(a[i]);
    pulse(d);
  endtask : group
  task automatic commit();
    lv(3'b111, 1310);
    lv(3'b000, 10);
  endtask : commit
endmodule : trim_fixture

/* verification/tb_reference_trim_programmer.sv */
// self-checking bench for the reference trim programmer
// assumes trim_fixture drives the pins and the checker is bound in
module tb_reference_trim_programmer;
  timeunit 1ns;
  timeprecision 1ps;
  import trim_prog_pkg::*;
  logic clk;
  logic reset;
  logic [TRIM_W-1:0] nvm_code;
  logic [TRIM_W-1:0] trim_code;
  logic signed [OFFSET_W-1:0] ref_offset_mv;
  nvm_cmd_t nvm_cmd;
  logic prog_active;
  pin_levels_t pins;
  logic [TRIM_W-1:0] exp_q[$];
  logic [TRIM_W-1:0] r;
  int miscompares = 0;
  int check_count = 0;
  int cyc = 0;
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  trim_fixture trim_fixture_i (.clk(clk), .pins(pins));
  reference_trim_programmer #(.COMMIT_CYCLES(1300)) reference_trim_programmer_i (.clk(clk), .reset(reset),
    .pin_levels(pins), .nvm_stored_code(nvm_code), .trim_code(trim_code), .ref_offset_mv(ref_offset_mv),
    .nvm_cmd(nvm_cmd), .prog_active(prog_active));
  task automatic chk(input string n, input logic [TRIM_W-1:0] seen, input logic [TRIM_W-1:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict
  task automatic write_code(input logic [TRIM_W-1:0] c);
    for (int b = 0; b < 4; b++)
      trim_fixture_i.group({4'h0, 2'(b)}, c[b]);
  endtask : write_code
  task automatic do_reset();
    reset <= 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : do_reset
  // store model and commit scoreboard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 90000)
    begin
      miscompares++;
      give_verdict();
    end
    if (!reset && nvm_cmd.write)
    begin
      nvm_code <= nvm_cmd.code;
      chk("commit code", nvm_cmd.code, exp_q.size() > 0 ? exp_q.pop_front() : 4'hx);
    end
  end
  initial
  begin
    reset = 1'b1;
    void'($urandom(54603));
    nvm_code = 4'($urandom);
    do_reset();
    chk("power-up code", trim_code, nvm_code);
    $display("test power-up done");
    trim_fixture_i.enter();
    for (int c = 0; c < 16; c++)
    begin
      write_code(4'(c));
      chk("trim code", trim_code, 4'(c));
    end
    $display("test all codes done");
    for (int k = 2; k < 6; k++)
      trim_fixture_i.group(6'(1 << k), 1'b0);
    chk("bad address", trim_code, 4'hf);
    repeat (3) trim_fixture_i.pulse(1'b0);
    trim_fixture_i.lv(3'b000, 20);
    trim_fixture_i.enter();
    trim_fixture_i.group(6'h01, 1'b0);
    chk("after abort", trim_code, 4'hd);
    chk("active flag", 4'(prog_active), 4'h1);
    $display("test refusals done");
    r = 4'($urandom);
    write_code(r);
    exp_q.push_back(r);
    trim_fixture_i.commit();
    repeat (5) @(posedge clk);
    chk("pending commits", 4'(exp_q.size()), 4'h0);
    trim_fixture_i.enter();
    trim_fixture_i.group(6'h00, ~r[0]);
    chk("volatile bit", trim_code, {r[3:1], ~r[0]});
    trim_fixture_i.lv(3'b000, 5);
    chk("idle flag", 4'(prog_active), 4'h0);
    do_reset();
    chk("reload", trim_code, r);
    $display("test commit done");
    give_verdict();
  end
endmodule : tb_reference_trim_programmer
